// ==== src/amsdl_top.sv ====
// mode sequencer: menu, confirmed deploy and stow, locate position gathering
// assumes keypad events are one-cycle pulses and sensor answers are pulses
`timescale 1ns/1ps
`include "amsdl_consts.svh"
module amsdl_top
  import amsdl_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = `AMSDL_FLASH_MS * `AMSDL_MS_CYCLES,
  parameter int unsigned RESP_CYCLES = `AMSDL_RESP_MS * `AMSDL_MS_CYCLES,
  parameter amsdl_ang_t VAR_K_LAT = 16'sh0010,
  parameter amsdl_ang_t VAR_K_LON = 16'sh0020,
  parameter amsdl_ang_t VAR_K_TIME = 16'sh0001
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key_valid,
  input wire logic [4:0] key_code,
  input wire logic sats_saved,
  input wire amsdl_axes_t axis_pos,
  input wire amsdl_axes_t deploy_target,
  input wire amsdl_axes_t stow_target,
  input wire logic az_stow_switch,
  input wire logic pol_stow_enable,
  input wire logic pol_switch_fitted,
  input wire logic pol_stow_switch,
  input wire logic el_stow_limit,
  input wire logic gps_fitted,
  input wire logic gps_resp,
  input wire logic gps_fix_valid,
  input wire amsdl_ang_t gps_lat,
  input wire amsdl_ang_t gps_lon,
  input wire logic [15:0] utc_time,
  input wire logic compass_fitted,
  input wire logic compass_resp,
  input wire amsdl_ang_t compass_heading,
  output amsdl_mode_t mode,
  output logic show_recall_delete,
  output logic [2:0] drive_pos,
  output logic [2:0] drive_neg,
  output logic [2:0] label_flash,
  output amsdl_axes_t shown_target,
  output logic show_targets,
  output logic gps_poll,
  output logic compass_poll,
  output amsdl_ang_t lat,
  output amsdl_ang_t lon,
  output amsdl_ang_t heading,
  output logic lat_stars,
  output logic lon_stars,
  output logic heading_stars,
  output amsdl_status_t status,
  output logic magnetic_variation_calc_flash
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  amsdl_mode_t mode_d, mode_q;
  logic [31:0] tmr_d, tmr_q;
  amsdl_ang_t lat_d, lat_q, lon_d, lon_q, hdg_d, hdg_q;
  logic lat_v_d, lat_v_q, lon_v_d, lon_v_q, hdg_v_d, hdg_v_q;
  logic signed [31:0] var_d, var_q;
  logic [1:0] vstep_d, vstep_q;
  amsdl_status_t st_d, st_q;
  logic gpoll_d, gpoll_q, cpoll_d, cpoll_q;
  logic [2:0] en;
  logic [2:0] at;
  amsdl_axes_t tgt;
  logic phase;
  logic run;
  logic k_mode, k_bksp, k_stop;
  logic signed [31:0] prod;
  logic signed [16:0] hsum;

  assign k_mode = key_valid && (key_code == KEY_MODE);
  assign k_bksp = key_valid && (key_code == KEY_BKSP);
  assign k_stop = key_valid && (key_code == KEY_STOP);

  // only one axis is enabled per state, so axes move one after another
  always_comb begin
    en = 3'b000;
    tgt = stow_target;
    unique case (mode_q)
      M_DEP_AZ: en[`AMSDL_AX_AZ] = 1'b1;
      M_DEP_POL: en[`AMSDL_AX_POL] = 1'b1;
      M_DEP_EL: en[`AMSDL_AX_EL] = 1'b1;
      M_STOW_AZ, M_SRCH_P, M_SRCH_N: en[`AMSDL_AX_AZ] = 1'b1;
      M_STOW_POL: en[`AMSDL_AX_POL] = 1'b1;
      M_STOW_EL: en[`AMSDL_AX_EL] = 1'b1;
      default: en = 3'b000;
    endcase
    if (mode_q inside {M_DEP_AZ, M_DEP_POL, M_DEP_EL}) begin
      tgt = deploy_target;
    end
    // search swings a short span either side of the stow point
    if (mode_q == M_SRCH_P) begin
      tgt[`AMSDL_AX_AZ] = stow_target[`AMSDL_AX_AZ] + `AMSDL_SRCH_SPAN;
    end
    if (mode_q == M_SRCH_N) begin
      tgt[`AMSDL_AX_AZ] = stow_target[`AMSDL_AX_AZ] - `AMSDL_SRCH_SPAN;
    end
  end

  for (genvar i = 0; i < `AMSDL_AXIS_N; i++) begin : g_axis
    amsdl_axis_drive u_drive (
      .clk(clk),
      .rst_n(rst_n),
      .enable(en[i] && !k_stop),
      .target(tgt[i]),
      .position(axis_pos[i]),
      .at_target(at[i]),
      .drive_pos(drive_pos[i]),
      .drive_neg(drive_neg[i])
    );
    assign label_flash[i] = en[i] && phase;
  end

  amsdl_flasher #(.HALF_CYCLES(FLASH_CYCLES)) u_flash (
    .clk(clk),
    .rst_n(rst_n),
    .phase(phase)
  );

  assign run = mode_q inside {M_DEP_AZ, M_DEP_POL, M_DEP_EL, M_STOW_AZ, M_SRCH_P,
                              M_SRCH_N, M_STOW_POL, M_STOW_EL};

  always_comb begin
    unique case (vstep_q)
      2'h0: prod = lat_q * VAR_K_LAT;
      2'h1: prod = lon_q * VAR_K_LON;
      default: prod = $signed({1'b0, utc_time}) * VAR_K_TIME;
    endcase
    // heading sign-extended, variation truncated to 17 bits, so a westerly (negative) variation subtracts
    hsum = 17'(compass_heading) + 17'(var_q);
    if (hsum < 17'sh00000) begin
      hsum = hsum + `AMSDL_FULL_TURN;
    end else if (hsum >= `AMSDL_FULL_TURN) begin
      hsum = hsum - `AMSDL_FULL_TURN;
    end
  end

  always_comb begin
    mode_d = mode_q;
    tmr_d = tmr_q;
    lat_d = lat_q;
    lon_d = lon_q;
    hdg_d = hdg_q;
    lat_v_d = lat_v_q;
    lon_v_d = lon_v_q;
    hdg_v_d = hdg_v_q;
    var_d = var_q;
    vstep_d = vstep_q;
    st_d = st_q;
    gpoll_d = 1'b0;
    cpoll_d = 1'b0;
    unique case (mode_q)
      M_MANUAL: if (k_mode) mode_d = M_MENU;
      M_MENU: begin
        if (k_mode) begin
          mode_d = M_MANUAL;
        end else if (key_valid) begin
          unique case (key_code)
            KEY_1: mode_d = M_DEP_ASK;
            KEY_2: mode_d = M_STOW_ASK;
            KEY_3: mode_d = (lat_v_q && lon_v_q && hdg_v_q) ? M_LOC_SHOW : M_LOC_GPS;
            KEY_4: mode_d = M_STORE;
            KEY_5: if (sats_saved) mode_d = M_RECALL;
            KEY_6: if (sats_saved) mode_d = M_DELETE;
            KEY_7: mode_d = M_POSITION;
            KEY_8: mode_d = M_SETTINGS;
            default: mode_d = M_MENU;
          endcase
        end
      end
      M_DEP_ASK: begin
        if (k_bksp) mode_d = M_DEP_AZ;
        else if (k_mode) mode_d = M_MENU;
      end
      M_STOW_ASK: begin
        if (k_bksp) mode_d = M_STOW_AZ;
        else if (k_mode) mode_d = M_MENU;
      end
      M_DEP_AZ: if (at[`AMSDL_AX_AZ]) mode_d = M_DEP_POL;
      M_DEP_POL: if (at[`AMSDL_AX_POL]) mode_d = M_DEP_EL;
      M_DEP_EL: if (at[`AMSDL_AX_EL]) mode_d = M_MANUAL;
      M_STOW_AZ: begin
        if (at[`AMSDL_AX_AZ]) begin
          mode_d = az_stow_switch ? M_STOW_POL : M_SRCH_P;
        end
      end
      M_SRCH_P: begin
        if (az_stow_switch) mode_d = M_STOW_POL;
        else if (at[`AMSDL_AX_AZ]) mode_d = M_SRCH_N;
      end
      M_SRCH_N: begin
        if (az_stow_switch) begin
          mode_d = M_STOW_POL;
        end else if (at[`AMSDL_AX_AZ]) begin
          mode_d = M_STOW_FLT;
          st_d.azimuth_park_fault = 1'b1;
        end
      end
      M_STOW_POL: begin
        if (!pol_stow_enable) begin
          mode_d = M_STOW_EL;
        end else if (at[`AMSDL_AX_POL]) begin
          if (pol_switch_fitted && !pol_stow_switch) begin
            mode_d = M_STOW_FLT;
            st_d.polarization_park_fault = 1'b1;
          end else begin
            mode_d = M_STOW_EL;
          end
        end
      end
      M_STOW_EL: if (el_stow_limit || at[`AMSDL_AX_EL]) mode_d = M_MANUAL;
      M_STOW_FLT: begin
        // the fault message stays until the mode key
        if (k_mode) begin
          mode_d = M_MENU;
          st_d.azimuth_park_fault = 1'b0;
          st_d.polarization_park_fault = 1'b0;
        end
      end
      M_LOC_GPS: begin
        st_d.receiver_silent_error = 1'b0;
        st_d.fix_pending_status = 1'b0;
        if (gps_fitted) begin
          gpoll_d = 1'b1;
          tmr_d = RESP_CYCLES;
          mode_d = M_LOC_GWAIT;
        end else begin
          mode_d = M_LOC_SHOW;
        end
      end
      M_LOC_GWAIT: begin
        tmr_d = tmr_q - 32'h0000_0001;
        if (gps_resp && gps_fix_valid) begin
          lat_d = gps_lat;
          lon_d = gps_lon;
          lat_v_d = 1'b1;
          lon_v_d = 1'b1;
          var_d = 32'sh0000_0000;
          vstep_d = 2'h0;
          mode_d = M_LOC_VAR;
        end else if (gps_resp) begin
          st_d.fix_pending_status = 1'b1;
          mode_d = M_LOC_SHOW;
        end else if (tmr_q == 32'h0000_0000) begin
          st_d.receiver_silent_error = 1'b1;
          mode_d = M_LOC_SHOW;
        end
      end
      M_LOC_VAR: begin
        // three-term linear variation model, one term per cycle
        var_d = var_q + (prod >>> 8);
        vstep_d = vstep_q + 2'h1;
        if (vstep_q == 2'h2) mode_d = M_LOC_CMP;
      end
      M_LOC_CMP: begin
        if (compass_fitted) begin
          cpoll_d = 1'b1;
          tmr_d = RESP_CYCLES;
          mode_d = M_LOC_CWAIT;
        end else begin
          mode_d = M_LOC_SHOW;
        end
      end
      M_LOC_CWAIT: begin
        tmr_d = tmr_q - 32'h0000_0001;
        if (compass_resp) begin
          hdg_d = hsum[15:0];
          hdg_v_d = 1'b1;
          mode_d = M_LOC_SHOW;
        end else if (tmr_q == 32'h0000_0000) begin
          mode_d = M_LOC_SHOW;
        end
      end
      M_LOC_SHOW, M_STORE, M_RECALL, M_DELETE, M_POSITION, M_SETTINGS: begin
        if (k_mode) mode_d = M_MENU;
      end
      default: mode_d = M_MANUAL;
    endcase
    if (run && k_stop) begin
      mode_d = M_MANUAL;
    end
    st_d.magnetic_variation_calc = (mode_d == M_LOC_VAR);
    st_d.param_needed = !(lat_v_d && lon_v_d && hdg_v_d);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= M_MANUAL;
      tmr_q <= 32'h0000_0000;
      lat_q <= 16'sh0000;
      lon_q <= 16'sh0000;
      hdg_q <= 16'sh0000;
      lat_v_q <= 1'b0;
      lon_v_q <= 1'b0;
      hdg_v_q <= 1'b0;
      var_q <= 32'sh0000_0000;
      vstep_q <= 2'h0;
      st_q <= '{param_needed: 1'b1, default: 1'b0};
      gpoll_q <= 1'b0;
      cpoll_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      tmr_q <= tmr_d;
      lat_q <= lat_d;
      lon_q <= lon_d;
      hdg_q <= hdg_d;
      lat_v_q <= lat_v_d;
      lon_v_q <= lon_v_d;
      hdg_v_q <= hdg_v_d;
      var_q <= var_d;
      vstep_q <= vstep_d;
      st_q <= st_d;
      gpoll_q <= gpoll_d;
      cpoll_q <= cpoll_d;
    end
  end

  assign mode = mode_q;
  assign show_recall_delete = sats_saved;
  assign shown_target = tgt;
  assign show_targets = run;
  assign gps_poll = gpoll_q;
  assign compass_poll = cpoll_q;
  assign lat = lat_q;
  assign lon = lon_q;
  assign heading = hdg_q;
  assign lat_stars = !lat_v_q;
  assign lon_stars = !lon_v_q;
  assign heading_stars = !hdg_v_q;
  assign status = st_q;
  assign magnetic_variation_calc_flash = st_q.magnetic_variation_calc && phase;

  menu_manual_a: assert property (mode_q == M_MENU && k_mode |=> mode_q == M_MANUAL)
    else $error("mode key in menu did not enter manual");
  recall_refuse_a: assert property (mode_q == M_MENU && key_valid && !sats_saved
    && key_code inside {KEY_5, KEY_6} |=> mode_q == M_MENU)
    else $error("recall or delete taken with nothing saved");
  deploy_pick_a: assert property (mode_q == M_MENU && key_valid && key_code == KEY_1
    |=> mode_q == M_DEP_ASK)
    else $error("digit one did not open deploy");
  confirm_still_a: assert property (mode_q inside {M_DEP_ASK, M_STOW_ASK}
    |-> (drive_pos | drive_neg) == 3'b000)
    else $error("axis driven before confirmation");
  prompt_exit_a: assert property (mode_q == M_DEP_ASK && k_mode
    |=> mode_q == M_MENU ##1 (drive_pos | drive_neg) == 3'b000)
    else $error("deploy prompt exit moved an axis");
  stop_abort_a: assert property (run && k_stop
    |-> (drive_pos | drive_neg) == 3'b000 ##1 mode_q == M_MANUAL)
    else $error("stop key did not halt motion");
  one_axis_a: assert property ($onehot0(drive_pos | drive_neg))
    else $error("two axes driven at once");
  az_fault_a: assert property (mode_q == M_SRCH_N && at[0] && !az_stow_switch && !k_stop
    |=> mode_q == M_STOW_FLT && status.azimuth_park_fault)
    else $error("failed search gave no azimuth fault");
  el_order_a: assert property ($rose(mode_q == M_STOW_EL)
    |-> $past(mode_q) == M_STOW_POL && !status.azimuth_park_fault)
    else $error("elevation stow started out of order");
  silent_rx_a: assert property (mode_q == M_LOC_GWAIT && tmr_q == 32'h0 && !gps_resp
    |=> status.receiver_silent_error)
    else $error("silent receiver not reported");
  gps_first_a: assert property (cpoll_q |-> lat_v_q && lon_v_q)
    else $error("compass polled before a receiver fix");
  stars_flag_a: assert property (heading_stars |-> status.param_needed)
    else $error("missing heading without parameter needed");
endmodule : amsdl_top

// ==== src/amsdl_consts.svh ====
// constants of the antenna menu, stow, deploy and locate sequencer
// assumes a 100 MHz clock; angles are signed tenths of a degree
// Operation
// - mode key in menu enters manual
// - recall and delete hidden without saved satellites
// - digits 1 to 8 select menu sub-modes
// - deploy moves only after confirm key
// - mode key at deploy prompt returns, no motion
// - flash moving axis label, show targets
// - deploy complete enters manual
// - stop key aborts deploy or stow at once
// - stow needs same confirm as deploy
// - stow azimuth first, then check its switch
// - missing azimuth switch triggers side-to-side search
// - failed search gives azimuth fault, stops sequence
// - optional polarization stow, fault if switch unconfirmed
// - elevation stows last, ends at stow limit
// - stow complete enters manual
// - locate without position acquires from sensors
// - invalid field shows stars, parameter needed
// - poll receiver first, report silent receiver
// - receiver without fix shows fix pending
// - compute variation, poll compass, form true heading
`ifndef AMSDL_CONSTS_SVH
`define AMSDL_CONSTS_SVH
`define AMSDL_CLK_MHZ 100
`define AMSDL_AX_AZ 0
`define AMSDL_AX_EL 1
`define AMSDL_AX_POL 2
`define AMSDL_AXIS_N 3
`define AMSDL_POS_TOL 16'sh0002
`define AMSDL_SRCH_SPAN 16'sh0032
`define AMSDL_FULL_TURN 17'sh00e10
`define AMSDL_FLASH_MS 250
`define AMSDL_RESP_MS 1000
`define AMSDL_MS_CYCLES (1000 * `AMSDL_CLK_MHZ)
`endif

// ==== src/amsdl_pkg.sv ====
// types shared by the sequencer, its axis drive and the test bench
// assumes amsdl_consts.svh for all numeric constants
package amsdl_pkg;
  typedef logic signed [15:0] amsdl_ang_t;
  typedef amsdl_ang_t [2:0] amsdl_axes_t;
  typedef enum logic [4:0] {
    KEY_1 = 5'h01, KEY_2 = 5'h02, KEY_3 = 5'h03, KEY_4 = 5'h04,
    KEY_5 = 5'h05, KEY_6 = 5'h06, KEY_7 = 5'h07, KEY_8 = 5'h08,
    KEY_MODE = 5'h0a, KEY_BKSP = 5'h0b, KEY_STOP = 5'h0c, KEY_ENTER = 5'h0d
  } amsdl_key_t;
  typedef enum logic [4:0] {
    M_MANUAL = 5'h00, M_MENU = 5'h01, M_DEP_ASK = 5'h02, M_DEP_AZ = 5'h03,
    M_DEP_POL = 5'h04, M_DEP_EL = 5'h05, M_STOW_ASK = 5'h06, M_STOW_AZ = 5'h07,
    M_SRCH_P = 5'h08, M_SRCH_N = 5'h09, M_STOW_POL = 5'h0a, M_STOW_EL = 5'h0b,
    M_STOW_FLT = 5'h0c, M_LOC_GPS = 5'h0d, M_LOC_GWAIT = 5'h0e, M_LOC_VAR = 5'h0f,
    M_LOC_CMP = 5'h10, M_LOC_CWAIT = 5'h11, M_LOC_SHOW = 5'h12, M_STORE = 5'h13,
    M_RECALL = 5'h14, M_DELETE = 5'h15, M_POSITION = 5'h16, M_SETTINGS = 5'h17
  } amsdl_mode_t;
  typedef struct packed {
    logic azimuth_park_fault;
    logic polarization_park_fault;
    logic receiver_silent_error;
    logic fix_pending_status;
    logic magnetic_variation_calc;
    logic param_needed;
  } amsdl_status_t;
endpackage : amsdl_pkg

// ==== src/amsdl_axis_drive.sv ====
// one axis drive: steps toward the target while enabled
// assumes position input follows the motor; direction outputs go to the drive
`timescale 1ns/1ps
`include "amsdl_consts.svh"
module amsdl_axis_drive
  import amsdl_pkg::*;
#(
  parameter amsdl_ang_t TOL = `AMSDL_POS_TOL
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire amsdl_ang_t target,
  input wire amsdl_ang_t position,
  output logic at_target,
  output logic drive_pos,
  output logic drive_neg
);
  logic signed [16:0] diff;
  logic drive_pos_d;
  logic drive_neg_d;
  logic drive_pos_q;
  logic drive_neg_q;

  always_comb begin
    diff = {position[15], position} - {target[15], target};
    at_target = (diff <= 17'(TOL)) && (diff >= -17'(TOL));
    drive_pos_d = enable && !at_target && diff[16];
    drive_neg_d = enable && !at_target && !diff[16];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_pos_q <= 1'b0;
      drive_neg_q <= 1'b0;
    end else begin
      drive_pos_q <= drive_pos_d;
      drive_neg_q <= drive_neg_d;
    end
  end

  // dropping enable stops the drive at once, without waiting for an edge
  assign drive_pos = drive_pos_q && enable;
  assign drive_neg = drive_neg_q && enable;
endmodule : amsdl_axis_drive

// ==== src/amsdl_flasher.sv ====
// blink phase for flashing display labels
// assumes a free-running clock
`timescale 1ns/1ps
`include "amsdl_consts.svh"
module amsdl_flasher #(
  parameter int unsigned HALF_CYCLES = `AMSDL_FLASH_MS * `AMSDL_MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic phase
);
  logic [31:0] cnt_d;
  logic [31:0] cnt_q;
  logic phase_d;
  logic phase_q;

  always_comb begin
    cnt_d = cnt_q + 32'h0000_0001;
    phase_d = phase_q;
    if (cnt_q >= HALF_CYCLES - 1) begin
      cnt_d = 32'h0000_0000;
      phase_d = !phase_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
      phase_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;
endmodule : amsdl_flasher

// ==== test/amsdl_far_model.sv ====
// far-side model: axis motors, stow switches, positioning receiver and compass
// assumes drive levels and one-cycle poll pulses from amsdl_top on one clock
`timescale 1ns/1ps
module amsdl_far_model
  import amsdl_pkg::*;
#(
  parameter amsdl_ang_t AZ0 = 16'sh0064,
  parameter amsdl_ang_t POL0 = 16'sh0028,
  parameter amsdl_ang_t POL_SW = 16'shfff6,
  parameter amsdl_ang_t EL_LIM = 16'shffec,
  parameter amsdl_ang_t LAT = 16'sh00a0,
  parameter amsdl_ang_t LON = 16'shfec0,
  parameter amsdl_ang_t HDG = 16'sh000a
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] drive_pos,
  input wire logic [2:0] drive_neg,
  input wire logic gps_poll,
  input wire logic compass_poll,
  input wire amsdl_ang_t az_sw_at,
  input wire logic pol_sw_ok,
  input wire logic gps_on,
  input wire logic comp_on,
  input wire logic fix_ok,
  output amsdl_axes_t axis_pos,
  output logic az_stow_switch,
  output logic pol_stow_switch,
  output logic el_stow_limit,
  output logic gps_resp,
  output logic gps_fix_valid,
  output amsdl_ang_t gps_lat,
  output amsdl_ang_t gps_lon,
  output logic compass_resp,
  output amsdl_ang_t compass_heading
);
  amsdl_axes_t pos_q;
  logic [2:0] gps_cnt_q;
  logic [2:0] cmp_cnt_q;
  // each driven axis moves one tenth of a degree per cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_q <= {POL0, 16'sh0000, AZ0};
      gps_cnt_q <= 3'h0;
      cmp_cnt_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        pos_q[i] <= drive_pos[i] ? pos_q[i] + 16'sh0001
                  : (drive_neg[i] ? pos_q[i] - 16'sh0001 : pos_q[i]);
      end
      gps_cnt_q <= (gps_poll && gps_on) ? 3'h5
                 : (gps_cnt_q != 3'h0 ? gps_cnt_q - 3'h1 : 3'h0);
      cmp_cnt_q <= (compass_poll && comp_on) ? 3'h4
                 : (cmp_cnt_q != 3'h0 ? cmp_cnt_q - 3'h1 : 3'h0);
    end
  end
  assign axis_pos = pos_q;
  assign az_stow_switch = (pos_q[0] >= az_sw_at - 2) && (pos_q[0] <= az_sw_at + 2);
  assign pol_stow_switch = pol_sw_ok && (pos_q[2] >= POL_SW - 2) && (pos_q[2] <= POL_SW + 2);
  assign el_stow_limit = pos_q[1] <= EL_LIM;
  assign gps_resp = gps_cnt_q == 3'h1;
  assign compass_resp = cmp_cnt_q == 3'h1;
  // answer data is only held with its pulse; otherwise show the inverse
  assign gps_fix_valid = gps_resp ? fix_ok : ~fix_ok;
  assign gps_lat = gps_resp ? LAT : ~LAT;
  assign gps_lon = gps_resp ? LON : ~LON;
  assign compass_heading = compass_resp ? HDG : ~HDG;
endmodule : amsdl_far_model

// ==== test/amsdl_top_tb.sv ====
// self-checking bench for amsdl_top: keypad sequences against a far-side model
// assumes amsdl_far_model stands in for motors, switches and sensors
`timescale 1ns/1ps
module amsdl_top_tb;
  import amsdl_pkg::*;
  localparam int RESP = 20;
  logic clk, rst_n, key_valid, sats_saved, pol_stow_enable, pol_switch_fitted, gps_fitted;
  logic compass_fitted, pol_sw_ok, gps_on, comp_on, fix_ok, az_stow_switch, pol_stow_switch;
  logic el_stow_limit, gps_resp, gps_fix_valid, compass_resp, show_recall_delete, show_targets;
  logic gps_poll, compass_poll, lat_stars, lon_stars, heading_stars, magnetic_variation_calc_flash;
  logic [4:0] key_code;
  logic [15:0] utc_time;
  logic [2:0] drive_pos, drive_neg, label_flash;
  amsdl_axes_t axis_pos, deploy_target, stow_target, shown_target;
  amsdl_ang_t az_sw_at, gps_lat, gps_lon, compass_heading, lat, lon, heading;
  amsdl_mode_t mode;
  amsdl_status_t status;
  int fails, n_tests, bad_moves;
  amsdl_mode_t digit_mode [0:4] = '{M_STORE, M_RECALL, M_DELETE, M_POSITION, M_SETTINGS};

  amsdl_top #(.FLASH_CYCLES(4), .RESP_CYCLES(RESP)) dut_u (
    .clk, .rst_n, .key_valid, .key_code, .sats_saved, .axis_pos, .deploy_target, .stow_target,
    .az_stow_switch, .pol_stow_enable, .pol_switch_fitted, .pol_stow_switch, .el_stow_limit,
    .gps_fitted, .gps_resp, .gps_fix_valid, .gps_lat, .gps_lon, .utc_time, .compass_fitted,
    .compass_resp, .compass_heading, .mode, .show_recall_delete, .drive_pos, .drive_neg,
    .label_flash, .shown_target, .show_targets, .gps_poll, .compass_poll, .lat, .lon, .heading,
    .lat_stars, .lon_stars, .heading_stars, .status, .magnetic_variation_calc_flash
  );
  amsdl_far_model far_u (
    .clk, .rst_n, .drive_pos, .drive_neg, .gps_poll, .compass_poll, .az_sw_at, .pol_sw_ok,
    .gps_on, .comp_on, .fix_ok, .axis_pos, .az_stow_switch, .pol_stow_switch, .el_stow_limit,
    .gps_resp, .gps_fix_valid, .gps_lat, .gps_lon, .compass_resp, .compass_heading
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // no motion while idle or waiting; only azimuth moves during its own steps
  always @(posedge clk) begin
    if (rst_n && (mode inside {M_MENU, M_DEP_ASK, M_STOW_ASK, M_STOW_FLT})
        && |(drive_pos | drive_neg)) bad_moves++;
    if (rst_n && (mode inside {M_DEP_AZ, M_STOW_AZ, M_SRCH_P, M_SRCH_N})
        && |((drive_pos | drive_neg) & 3'h6)) bad_moves++;
    if (rst_n && magnetic_variation_calc_flash && !status.magnetic_variation_calc) bad_moves++;
  end

  task automatic conclude();
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk_bit

  task automatic chk_mode(input amsdl_mode_t exp, input string msg);
    chk_bit(mode === exp, 1'b1, msg);
  endtask : chk_mode

  task automatic chk_ang(input amsdl_ang_t got, input amsdl_ang_t exp, input string msg);
    chk_bit(got === exp, 1'b1, msg);
  endtask : chk_ang

  function automatic logic near(input amsdl_ang_t a, input amsdl_ang_t b);
    return (a - b <= 2) && (b - a <= 2);
  endfunction : near

  function automatic logic flag(input int sel);
    case (sel)
      0: return label_flash[0];
      1: return gps_poll;
      2: return compass_poll;
      3: return status.receiver_silent_error;
      4: return status.fix_pending_status;
      default: return status.magnetic_variation_calc;
    endcase
  endfunction : flag

  task automatic press(input logic [4:0] k);
    key_code = k;
    key_valid = 1'b1;
    @(posedge clk);
    #1;
    key_valid = 1'b0;
    // one idle edge keeps back-to-back presses apart
    @(posedge clk);
    #1;
  endtask : press

  task automatic wait_mode(input amsdl_mode_t m, input int bound, input string msg);
    for (int i = 0; i < bound && mode !== m; i++) begin
      @(posedge clk);
      #1;
    end
    chk_mode(m, msg);
    if (mode !== m) conclude();
  endtask : wait_mode

  task automatic wait_flag(input int sel, input int bound, input string msg);
    for (int i = 0; i < bound && flag(sel) !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk_bit(flag(sel), 1'b1, msg);
    if (flag(sel) !== 1'b1) conclude();
  endtask : wait_flag

  task automatic to_menu();
    press(KEY_MODE);
    if (mode === M_MANUAL) press(KEY_MODE);
    chk_mode(M_MENU, "back to menu");
  endtask : to_menu

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    $display("[ERR] %0t watchdog", $time);
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    key_valid = 1'b0;
    key_code = 5'h00;
    sats_saved = 1'b0;
    pol_stow_enable = 1'b1;
    pol_switch_fitted = 1'b1;
    gps_fitted = 1'b1;
    compass_fitted = 1'b1;
    utc_time = 16'h0100;
    deploy_target = {16'sh0000, 16'sh003c, 16'sh0014};
    stow_target = {16'shfff6, 16'shffe2, 16'sh0000};
    az_sw_at = 16'sh001e;
    pol_sw_ok = 1'b1;
    gps_on = 1'b0;
    comp_on = 1'b0;
    fix_ok = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk_mode(M_MANUAL, "reset mode");
    chk_bit(status === 6'h01 && lat_stars === 1'b1, 1'b1, "reset status");
    press(KEY_MODE);
    chk_mode(M_MENU, "manual to menu");
    press(KEY_MODE);
    chk_mode(M_MANUAL, "menu mode key");
    press(KEY_MODE);
    chk_bit(show_recall_delete, 1'b0, "recall shown");
    press(KEY_5);
    chk_mode(M_MENU, "recall taken");
    press(KEY_6);
    chk_mode(M_MENU, "delete taken");
    sats_saved = 1'b1;
    for (int i = 0; i < 5; i++) begin
      press(5'(i + 4));
      chk_mode(digit_mode[i], "digit mode");
      press(KEY_MODE);
    end
    press(KEY_1);
    chk_mode(M_DEP_ASK, "deploy prompt");
    repeat (5) @(posedge clk);
    #1;
    chk_ang(axis_pos[0], 16'sh0064, "moved before confirm");
    press(KEY_MODE);
    chk_mode(M_MENU, "deploy cancel");
    press(KEY_1);
    press(KEY_BKSP);
    chk_mode(M_DEP_AZ, "deploy start");
    chk_bit(show_targets === 1'b1 && shown_target === deploy_target, 1'b1, "targets");
    wait_flag(0, 20, "az label flash");
    wait_mode(M_MANUAL, 400, "deploy end");
    for (int i = 0; i < 3; i++) begin
      chk_bit(near(axis_pos[i], deploy_target[i]), 1'b1, "deploy pos");
    end
    press(KEY_MODE);
    press(KEY_2);
    chk_mode(M_STOW_ASK, "stow prompt");
    press(KEY_MODE);
    chk_mode(M_MENU, "stow cancel");
    press(KEY_2);
    press(KEY_BKSP);
    chk_mode(M_STOW_AZ, "stow start");
    repeat (4) @(posedge clk);
    #1;
    chk_bit(drive_neg[0], 1'b1, "az toward stow");
    key_code = KEY_STOP;
    key_valid = 1'b1;
    #1;
    chk_bit((drive_pos | drive_neg) === 3'h0, 1'b1, "stop drives");
    @(posedge clk);
    #1;
    key_valid = 1'b0;
    chk_mode(M_MANUAL, "stop mode");
    @(posedge clk);
    #1;
    press(KEY_MODE);
    press(KEY_2);
    press(KEY_BKSP);
    wait_mode(M_SRCH_P, 100, "search");
    wait_mode(M_STOW_POL, 200, "pol after az");
    wait_mode(M_STOW_EL, 200, "el after pol");
    wait_mode(M_MANUAL, 300, "stow end");
    chk_bit(axis_pos[1] > -16'sh001a && axis_pos[1] < -16'sh0011, 1'b1, "el limit");
    az_sw_at = 16'sh0100;
    press(KEY_MODE);
    press(KEY_2);
    press(KEY_BKSP);
    wait_mode(M_STOW_FLT, 400, "az fault");
    chk_bit(status.azimuth_park_fault, 1'b1, "az fault flag");
    press(KEY_MODE);
    chk_bit(mode === M_MENU && !status.azimuth_park_fault, 1'b1, "fault exit");
    az_sw_at = 16'sh0000;
    pol_sw_ok = 1'b0;
    press(KEY_2);
    press(KEY_BKSP);
    wait_mode(M_STOW_FLT, 600, "pol fault");
    chk_bit(status.polarization_park_fault, 1'b1, "pol fault flag");
    press(KEY_MODE);
    press(KEY_3);
    wait_flag(1, 5, "receiver poll");
    wait_flag(3, RESP + 20, "silent receiver");
    chk_bit(lat_stars && status.param_needed, 1'b1, "stars");
    repeat (RESP + 20) @(posedge clk);
    #1;
    to_menu();
    gps_on = 1'b1;
    press(KEY_3);
    wait_flag(4, 30, "fix pending");
    chk_bit(lat_stars, 1'b1, "no fix stars");
    repeat (2 * RESP + 20) @(posedge clk);
    #1;
    to_menu();
    fix_ok = 1'b1;
    comp_on = 1'b1;
    press(KEY_3);
    wait_flag(1, 5, "receiver poll");
    wait_flag(5, 30, "variation");
    wait_flag(2, 10, "compass poll");
    wait_mode(M_LOC_SHOW, 40, "locate show");
    chk_ang(lat, 16'sh00a0, "lat");
    chk_ang(lon, 16'shfec0, "lon");
    chk_ang(heading, 16'sh0dfd, "true heading");
    chk_bit(lat_stars | lon_stars | heading_stars | status.param_needed, 1'b0, "valid");
    to_menu();
    press(KEY_3);
    chk_mode(M_LOC_SHOW, "locate held");
    chk_bit(bad_moves == 0, 1'b1, "stray motion");
    conclude();
  end
endmodule : amsdl_top_tb
